/* File: core/bit_sync.sv */
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	// Clock and reset of the receiving domain
	input  wire logic         clk,
	input  wire logic         rst,
	// Asynchronous level in, synchronised level out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} sync_s;

	sync_s s_ff;
	sync_s nxt_s;

	// First stage feeds only the second stage
	always_comb begin
		nxt_s.meta = d;
		nxt_s.q    = s_ff.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign q = s_ff.q;
endmodule
`default_nettype wire

/* File: core/radio_mode_packet_controller.sv */
// Mode selection, packet queues and framing engine of the radio core
//
// Operation
// RL1: Power on, receive select and chip enable high give active receive.
// RL2: Power on, transmit select, enable high: send until transmit queue empty.
// RL3: Enable falling during a send keeps transmit until that packet ends.
// RL4: Transmitter with enable high and empty queue rests in ready idle.
// RL5: Power on with enable low gives low standby once no send runs.
// RL6: Power bit low forces power-down whatever enable and receive select.
// RL7: Host pulses enable over 10 us to send, holds it to receive.
// RL8: Configuration kept and host access accepted in both standby levels.
// RL9: Power-down keeps all host-visible values and still answers the host.
// RL10: Two packet methods: legacy burst and acknowledged with retransmission.
// RL11: Legacy receive raises interrupt when a valid packet enters queue.
// RL12: Legacy transmit builds preamble and checksum without host help.
// RL13: Legacy transmit raises interrupt when a packet has been sent.
// RL14: Receive queue three entries deep, shared by six receive pipes.
// RL15: Separate transmit queue three entries deep holds pending payloads.
// RL16: Host may read and write both queues in every mode.
// RL17: Acknowledged method acknowledges and retransmits without host help.
// RL18: Receive listening starts 130 us after enable rises.
// RL19: Interrupt stays active while a flag is set; host clears it.
// RL20: Interrupt low while any unmasked flag is set, else high.
// RL21: Host holds select low during each transaction, high between.
`timescale 1ns/100ps
`default_nettype none
module radio_mode_packet_controller
	import radio_pkg::*;
#(
	parameter int RX_SETTLE_CYCLES = RX_SETTLE_CYC,
	parameter int ACK_WAIT_CYCLES  = ACK_WAIT_CYC
) (
	// System clock and reset
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	// Link clock
	input  wire logic                link_clk,
	// Chip enable pin from the host
	input  wire logic                chip_enable,
	// Configuration bits
	input  wire logic                power_on_bit,
	input  wire logic                primary_receive_select,
	input  wire logic                acked_burst_method,
	input  wire logic [RETRY_W-1:0]  retry_limit,
	input  wire logic [ADDR_W-1:0]   tx_target_addr,
	input  wire logic [BASE_W-1:0]   rx_base_addr,
	// Transmit queue write port
	input  wire logic                tx_wr_valid,
	input  wire logic [DATA_W-1:0]   tx_wr_data,
	output logic                     tx_wr_ready,
	// Receive queue read port
	input  wire logic                rx_rd_ready,
	output logic                     rx_rd_valid,
	output rx_entry_s                rx_rd_entry,
	// Event flags and interrupt
	input  wire logic [N_FLAGS-1:0]  flag_clear,
	input  wire logic [N_FLAGS-1:0]  flag_mask,
	output logic                     receive_ready_flag,
	output logic                     transmit_done_flag,
	output logic                     retry_limit_flag,
	output logic                     irq_n,
	// Status
	output mode_e                    mode,
	output logic [RETRY_W-1:0]       retry_count,
	output logic [PTR_W-1:0]         tx_level,
	output logic [PTR_W-1:0]         rx_level,
	// Serial link, on link_clk
	output logic                     link_tx_bit,
	output logic                     link_tx_valid,
	input  wire logic                link_rx_bit,
	input  wire logic                link_rx_valid
);
	// System-side state
	typedef struct packed {
		mode_e                              mode;
		logic [CNT_W-1:0]                   timer;
		logic [RETRY_W-1:0]                 retries;
		logic [N_FLAGS-1:0]                 flags;
		logic                               req_tog;
		frame_s                             tx_frame;
		logic                               done_seen;
		logic                               rx_seen;
		logic [FIFO_DEPTH-1:0][DATA_W-1:0]  txq;
		logic [PTR_W-1:0]                   tx_rd;
		logic [PTR_W-1:0]                   tx_wr;
		logic [PTR_W-1:0]                   tx_cnt;
		rx_entry_s [FIFO_DEPTH-1:0]         rxq;
		logic [PTR_W-1:0]                   rx_rd;
		logic [PTR_W-1:0]                   rx_wr;
		logic [PTR_W-1:0]                   rx_cnt;
	} sys_s;

	// Link-side state
	typedef struct packed {
		logic [FRAME_W-1:0] tx_sh;
		logic [FCNT_W-1:0]  tx_cnt;
		logic               tx_busy;
		logic               req_seen;
		logic               done_tog;
		logic [FRAME_W-1:0] rx_sh;
		logic [FCNT_W-1:0]  rx_cnt;
		frame_s             rx_word;
		logic               rx_tog;
	} link_s;

	sys_s  s_ff;
	sys_s  nxt_s;
	link_s l_ff;
	link_s nxt_l;

	logic ce_s, done_s, rx_s;
	logic req_l, link_rst;

	// Checksum over header and payload
	function automatic logic [DATA_W-1:0] crc8(
		input logic [2*DATA_W-1:0] d
	);
		logic [DATA_W-1:0] c;
		c = CRC_INIT;
		for (int i = 2*DATA_W-1; i >= 0; i--) begin
			c = {c[DATA_W-2:0], 1'b0} ^ (c[DATA_W-1] ^ d[i] ? CRC_POLY : '0);
		end
		return c;
	endfunction

	// Wrap a queue index at the queue depth
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// Complete frame with preamble and checksum
	function automatic frame_s make_frame(input logic ack,
		input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] pl);
		return {PREAMBLE, ack, addr, pl, crc8({ack, addr, pl})};
	endfunction

	// Pin and link events into the system domain
	bit_sync #(.W(3)) u_sys_sync (
		.clk (sys_clk),
		.rst (sys_rst),
		.d   ({chip_enable, l_ff.done_tog, l_ff.rx_tog}),
		.q   ({ce_s, done_s, rx_s})
	);

	// Request toggle and reset into the link domain
	bit_sync #(.W(2)) u_link_sync (
		.clk (link_clk),
		.rst (1'b0),
		.d   ({s_ff.req_tog, sys_rst}),
		.q   ({req_l, link_rst})
	);

	// Mode sequencing, queues and flags
	always_comb begin
		logic               tx_push, rx_pop, tx_pop, rx_push;
		logic               go_idle, send, send_ack, done_ev;
		logic               rx_ev, frame_ok, busy, run_rx;
		logic [N_FLAGS-1:0] set;
		frame_s             rf;
		tx_pop   = 1'b0;
		rx_push  = 1'b0;
		go_idle  = 1'b0;
		send     = 1'b0;
		send_ack = 1'b0;
		set      = '0;
		nxt_s    = s_ff;
		rf       = l_ff.rx_word;
		// Queues answer the host in every mode, power-down included
		tx_push  = tx_wr_valid && (s_ff.tx_cnt != PTR_W'(FIFO_DEPTH)); // [RL16] [RL8] [RL9]
		rx_pop   = rx_rd_ready && (s_ff.rx_cnt != '0); // [RL16]
		done_ev  = done_s != s_ff.done_seen;
		rx_ev    = rx_s != s_ff.rx_seen;
		frame_ok = (rf.preamble == PREAMBLE)
			&& (rf.crc == crc8({rf.ack, rf.addr, rf.payload}));
		busy     = s_ff.req_tog != done_s;
		run_rx   = ce_s && primary_receive_select;
		nxt_s.done_seen = done_s;
		nxt_s.rx_seen   = rx_s;
		nxt_s.timer     = s_ff.timer + 1'b1;

		case (s_ff.mode)
			RX_SETTLE: begin
				if (!run_rx) begin
					go_idle = 1'b1;
				end else if (s_ff.timer == CNT_W'(RX_SETTLE_CYCLES - 1)) begin
					nxt_s.mode = RX_ACTIVE; // [RL18] [RL1]
				end
			end
			RX_ACTIVE: begin
				if (!run_rx) begin
					go_idle = 1'b1;
				end else if (rx_ev && frame_ok && !rf.ack
						&& rf.addr[ADDR_W-1:PIPE_W] == rx_base_addr
						&& rf.addr[PIPE_W-1:0] < PIPE_W'(PIPES)) begin
					// Full queue with no pop this cycle drops the packet unacknowledged
					if (s_ff.rx_cnt != PTR_W'(FIFO_DEPTH) || rx_pop) begin
						rx_push      = 1'b1; // [RL14]
						set[FLAG_RX] = 1'b1; // [RL11]
						if (acked_burst_method && !busy) begin
							send_ack   = 1'b1; // [RL17]
							nxt_s.mode = RX_ACK;
						end
					end
				end
			end
			RX_ACK: begin
				if (done_ev) begin
					if (run_rx) begin
						nxt_s.mode = RX_ACTIVE;
					end else begin
						go_idle = 1'b1;
					end
				end
			end
			TX_SEND: begin
				// Enable is ignored until the packet is out
				if (done_ev) begin // [RL3]
					if (acked_burst_method) begin
						nxt_s.mode  = TX_WAIT_ACK;
						nxt_s.timer = '0;
					end else begin
						tx_pop       = 1'b1;
						set[FLAG_TX] = 1'b1; // [RL13] [RL10]
						go_idle      = 1'b1;
					end
				end
			end
			TX_WAIT_ACK: begin
				if (rx_ev && frame_ok && rf.ack && rf.addr == tx_target_addr) begin
					tx_pop        = 1'b1; // [RL17]
					set[FLAG_TX]  = 1'b1;
					nxt_s.retries = '0;
					go_idle       = 1'b1;
				end else if (s_ff.timer == CNT_W'(ACK_WAIT_CYCLES - 1)) begin
					if (s_ff.retries == retry_limit) begin
						set[FLAG_RT] = 1'b1; // Head stays queued
						go_idle      = 1'b1;
					end else begin
						nxt_s.retries = s_ff.retries + 1'b1;
						send          = 1'b1; // [RL17]
					end
				end
			end
			default: begin
				go_idle = 1'b1;
			end
		endcase

		// Transmit queue
		if (tx_push) begin
			nxt_s.txq[s_ff.tx_wr] = tx_wr_data; // [RL15]
			nxt_s.tx_wr           = ptr_inc(s_ff.tx_wr);
		end
		if (tx_pop) begin
			nxt_s.tx_rd = ptr_inc(s_ff.tx_rd);
		end
		nxt_s.tx_cnt = s_ff.tx_cnt + PTR_W'(tx_push) - PTR_W'(tx_pop);

		// Receive queue, shared by all pipes
		if (rx_push) begin
			nxt_s.rxq[s_ff.rx_wr] = '{pipe: rf.addr[PIPE_W-1:0],
				data: rf.payload}; // [RL14]
			nxt_s.rx_wr = ptr_inc(s_ff.rx_wr);
		end
		if (rx_pop) begin
			nxt_s.rx_rd = ptr_inc(s_ff.rx_rd);
		end
		nxt_s.rx_cnt = s_ff.rx_cnt + PTR_W'(rx_push) - PTR_W'(rx_pop);

		// A set in the same cycle as its clear wins
		nxt_s.flags = (s_ff.flags & ~flag_clear) | set; // [RL19]

		// Pick the resting or working mode
		if (go_idle) begin
			if (!ce_s) begin
				nxt_s.mode = STBY_LOW; // [RL5]
			end else if (primary_receive_select) begin
				nxt_s.mode  = RX_SETTLE; // [RL1]
				nxt_s.timer = '0;
			end else if (nxt_s.tx_cnt != '0 && !nxt_s.flags[FLAG_RT] && !busy) begin
				// Head may be pushed this cycle, so read it after the write
				nxt_s.retries = '0;
				send          = 1'b1; // [RL2]
			end else begin
				nxt_s.mode = READY_IDLE; // [RL4]
			end
		end

		// Hand a frame to the link; word stays stable while busy
		if (send) begin
			nxt_s.tx_frame = make_frame(1'b0, tx_target_addr,
				nxt_s.txq[nxt_s.tx_rd]); // [RL12]
			nxt_s.req_tog  = ~s_ff.req_tog;
			nxt_s.mode     = TX_SEND;
		end else if (send_ack) begin
			nxt_s.tx_frame = make_frame(1'b1, rf.addr, '0);
			nxt_s.req_tog  = ~s_ff.req_tog;
		end

		// Power bit low forces the mode only; a frame request still reaches the link; queues and flags are kept
		if (!power_on_bit) begin
			nxt_s.mode = PWR_DOWN; // [RL6] [RL9]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Serialiser and deserialiser on the link clock
	always_comb begin
		nxt_l = l_ff;
		if (l_ff.tx_busy) begin
			nxt_l.tx_sh  = {l_ff.tx_sh[FRAME_W-2:0], 1'b0};
			nxt_l.tx_cnt = l_ff.tx_cnt + 1'b1;
			if (l_ff.tx_cnt == FCNT_W'(FRAME_W - 1)) begin
				nxt_l.tx_busy  = 1'b0;
				nxt_l.done_tog = ~l_ff.done_tog;
			end
		end else if (req_l != l_ff.req_seen) begin
			nxt_l.tx_sh    = s_ff.tx_frame; // [RL12]
			nxt_l.tx_cnt   = '0;
			nxt_l.tx_busy  = 1'b1;
			nxt_l.req_seen = req_l;
		end
		// Framing is the valid level; a gap restarts the count
		if (link_rx_valid) begin
			nxt_l.rx_sh  = {l_ff.rx_sh[FRAME_W-2:0], link_rx_bit};
			nxt_l.rx_cnt = l_ff.rx_cnt + 1'b1;
			if (l_ff.rx_cnt == FCNT_W'(FRAME_W - 1)) begin
				nxt_l.rx_word = {l_ff.rx_sh[FRAME_W-2:0], link_rx_bit};
				nxt_l.rx_tog  = ~l_ff.rx_tog;
			end
		end else begin
			nxt_l.rx_cnt = '0;
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			l_ff <= '0;
		end else begin
			l_ff <= nxt_l;
		end
	end

	// Outputs
	assign tx_wr_ready        = s_ff.tx_cnt != PTR_W'(FIFO_DEPTH);
	assign rx_rd_valid        = s_ff.rx_cnt != '0;
	assign rx_rd_entry        = s_ff.rxq[s_ff.rx_rd];
	assign receive_ready_flag = s_ff.flags[FLAG_RX];
	assign transmit_done_flag = s_ff.flags[FLAG_TX];
	assign retry_limit_flag   = s_ff.flags[FLAG_RT];
	assign irq_n              = ~|(s_ff.flags & ~flag_mask); // [RL20] [RL19]
	assign mode               = s_ff.mode;
	assign retry_count        = s_ff.retries;
	assign tx_level           = s_ff.tx_cnt;
	assign rx_level           = s_ff.rx_cnt;
	assign link_tx_bit        = l_ff.tx_sh[FRAME_W-1];
	assign link_tx_valid      = l_ff.tx_busy;
endmodule
`default_nettype wire

/* File: core/radio_pkg.sv */
// Shared constants, types and frame layout of the radio mode controller
package radio_pkg;
	// Clock and timing figures
	localparam int SYS_CLK_PS    = 5000;
	localparam int RX_SETTLE_US  = 130;
	localparam int ACK_WAIT_US   = 250;
	localparam int RX_SETTLE_CYC =
		(RX_SETTLE_US * 1000000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
	localparam int ACK_WAIT_CYC  = (ACK_WAIT_US * 1000000) / SYS_CLK_PS;
	localparam int CNT_W         = 17;

	// Payload, queue and frame sizes
	localparam int DATA_W      = 8;
	localparam int ADDR_W      = 7;
	localparam int BASE_W      = 4;
	localparam int PIPE_W      = 3;
	localparam int PIPES       = 6;
	localparam int FIFO_DEPTH  = 3;
	localparam int PTR_W       = 2;
	localparam int FRAME_W     = 32;
	localparam int FCNT_W      = 5;
	localparam int RETRY_W     = 4;

	// Frame constants
	localparam logic [DATA_W-1:0] PREAMBLE = 8'hAA;
	localparam logic [DATA_W-1:0] CRC_POLY = 8'h07;
	localparam logic [DATA_W-1:0] CRC_INIT = 8'hFF;

	// Event flag positions
	localparam int FLAG_RX = 0;
	localparam int FLAG_TX = 1;
	localparam int FLAG_RT = 2;
	localparam int N_FLAGS = 3;

	// Operating modes
	typedef enum logic [2:0] {
		PWR_DOWN,
		STBY_LOW,
		READY_IDLE,
		RX_SETTLE,
		RX_ACTIVE,
		RX_ACK,
		TX_SEND,
		TX_WAIT_ACK
	} mode_e;

	// Frame on the link, sent most significant bit first
	typedef struct packed {
		logic [DATA_W-1:0] preamble;
		logic              ack;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] payload;
		logic [DATA_W-1:0] crc;
	} frame_s;

	// Receive queue entry
	typedef struct packed {
		logic [PIPE_W-1:0] pipe;
		logic [DATA_W-1:0] data;
	} rx_entry_s;
endpackage

/* File: testbench/link_peer.sv */
// Far-end link peer: captures sent frames and plays frames back
`timescale 1ns/100ps
`default_nettype none
module link_peer
	import radio_pkg::*;
(
	// Link clock and wires
	input  wire logic link_clk,
	input  wire logic link_tx_bit,
	input  wire logic link_tx_valid,
	output logic      link_rx_bit,
	output logic      link_rx_valid,
	// Reply with acknowledge frames
	input  wire logic ack_en
);
	logic [31:0] sh;
	logic [31:0] got_frame;
	int          n;
	event        got;

	// Checksum over ack, address and payload, first bit first
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction
	function automatic logic [31:0] mk(input logic a, input logic [6:0] ad,
		input logic [7:0] p);
		return {PREAMBLE, a, ad, p, crc8({a, ad, p})};
	endfunction
	task automatic send(input logic [31:0] f);
		for (int i = 31; i >= 0; i--) begin
			@(posedge link_clk);
			#1;
			link_rx_valid = 1'b1;
			link_rx_bit   = f[i];
		end
		@(posedge link_clk);
		#1;
		link_rx_valid = 1'b0;
	endtask
	// Idle line toggles so a stale bit never reads as data
	initial begin
		link_rx_valid = 1'b0;
		link_rx_bit   = 1'b0;
		forever @(posedge link_clk) if (!link_rx_valid) link_rx_bit <= ~link_rx_bit;
	end
	// Shift in sent bits; a gap in valid restarts the frame
	initial begin
		n = 0;
		forever @(posedge link_clk) begin
			n = link_tx_valid ? n + 1 : 0;
			sh = {sh[30:0], link_tx_bit};
			if (n == FRAME_W) begin
				got_frame = sh;
				n = 0;
				-> got;
				if (ack_en && !sh[23]) fork
					send(mk(1'b1, sh[22:16], 8'h00));
				join_none
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/radio_ctrl_sva.sv */
// Port checker for the radio mode controller
`timescale 1ns/100ps
`default_nettype none
module radio_ctrl_sva
	import radio_pkg::*;
#(
	parameter int RX_SETTLE_CYCLES = RX_SETTLE_CYC
) (
	// Clocks and reset
	input wire logic               sys_clk,
	input wire logic               sys_rst,
	input wire logic               link_clk,
	// Host side
	input wire logic               power_on_bit,
	input wire logic               tx_wr_valid,
	input wire logic               tx_wr_ready,
	input wire logic [N_FLAGS-1:0] flag_clear,
	input wire logic [N_FLAGS-1:0] flag_mask,
	input wire logic               receive_ready_flag,
	input wire logic               transmit_done_flag,
	input wire logic               retry_limit_flag,
	input wire logic               irq_n,
	input wire mode_e              mode,
	input wire logic [PTR_W-1:0]   tx_level,
	// Link
	input wire logic               link_tx_bit,
	input wire logic               link_tx_valid
);
	logic [15:0] set_cnt_ff;
	logic [15:0] nxt_set_cnt;
	logic [2:0]  flags;
	// Settle run length; holds the count for one cycle after the settle state, else zero
	always_comb begin
		nxt_set_cnt = (mode == RX_SETTLE) ? set_cnt_ff + 16'h0001 : 16'h0000;
		flags = {retry_limit_flag, transmit_done_flag, receive_ready_flag};
	end
	always_ff @(posedge sys_clk) begin
		set_cnt_ff <= sys_rst ? 16'h0000 : nxt_set_cnt;
	end

	property p_irq;
		@(posedge sys_clk) disable iff (sys_rst) irq_n == ~|(flags & ~flag_mask);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt level disagrees with flags");
	property p_ready;
		@(posedge sys_clk) disable iff (sys_rst) tx_wr_ready == (tx_level != 2'h3);
	endproperty
	a_ready: assert property (p_ready)
		else $error("transmit ready disagrees with level");
	property p_pwrdn;
		@(posedge sys_clk) disable iff (sys_rst) !power_on_bit |=> mode == PWR_DOWN;
	endproperty
	a_pwrdn: assert property (p_pwrdn)
		else $error("power bit low but not powered down");
	property p_settle;
		@(posedge sys_clk) disable iff (sys_rst)
		mode == RX_ACTIVE && set_cnt_ff != 16'h0000 |-> set_cnt_ff == RX_SETTLE_CYCLES;
	endproperty
	a_settle: assert property (p_settle)
		else $error("receive settle time wrong");
	property p_txsend;
		@(posedge sys_clk) disable iff (sys_rst)
		mode == TX_SEND && link_tx_valid && power_on_bit |=> mode == TX_SEND;
	endproperty
	a_txsend: assert property (p_txsend)
		else $error("left transmit during a frame");
	property p_sticky;
		@(posedge sys_clk) disable iff (sys_rst)
		transmit_done_flag && !flag_clear[FLAG_TX] |=> transmit_done_flag;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("done flag dropped without clear");
	property p_keep;
		@(posedge sys_clk) disable iff (sys_rst)
		mode == PWR_DOWN && !tx_wr_valid |=> $stable(tx_level);
	endproperty
	a_keep: assert property (p_keep)
		else $error("queue level changed in power-down");
	property p_preamble;
		@(posedge link_clk) disable iff (sys_rst)
		$rose(link_tx_valid) |-> link_tx_bit ##1 !link_tx_bit ##1 link_tx_bit;
	endproperty
	a_preamble: assert property (p_preamble)
		else $error("frame does not open with preamble");
	c_rx: cover property (@(posedge sys_clk) mode == RX_ACTIVE);
	c_rt: cover property (@(posedge sys_clk) $rose(retry_limit_flag));
	c_tx: cover property (@(posedge sys_clk) $rose(transmit_done_flag));
endmodule

bind radio_mode_packet_controller radio_ctrl_sva #(
	.RX_SETTLE_CYCLES(RX_SETTLE_CYCLES)
) u_radio_ctrl_sva (.sys_clk, .sys_rst, .link_clk, .power_on_bit,
	.tx_wr_valid, .tx_wr_ready, .flag_clear, .flag_mask, .receive_ready_flag,
	.transmit_done_flag, .retry_limit_flag, .irq_n, .mode, .tx_level,
	.link_tx_bit, .link_tx_valid);
`default_nettype wire

/* File: testbench/radio_mode_packet_controller_tb_top.sv */
// Self-checking bench for the radio mode controller
`timescale 1ns/100ps
`default_nettype none
module radio_mode_packet_controller_tb_top
	import radio_pkg::*;
;
	logic sys_clk, sys_rst, link_clk, chip_enable, power_on_bit, ack_en;
	logic primary_receive_select, acked_burst_method, tx_wr_valid, rx_rd_ready;
	logic tx_wr_ready, rx_rd_valid, receive_ready_flag, transmit_done_flag;
	logic retry_limit_flag, irq_n, link_tx_bit, link_tx_valid;
	logic link_rx_bit, link_rx_valid;
	logic [RETRY_W-1:0] retry_limit, retry_count;
	logic [ADDR_W-1:0]  tx_target_addr;
	logic [BASE_W-1:0]  rx_base_addr;
	logic [DATA_W-1:0]  tx_wr_data, d;
	logic [DATA_W-1:0]  pl [4];
	logic [N_FLAGS-1:0] flag_clear, flag_mask;
	logic [PTR_W-1:0]   tx_level, rx_level;
	rx_entry_s          rx_rd_entry;
	mode_e              mode;
	int                 fails, checked, seed;
	logic [31:0]        exp_q [$];
	wire [4:0] evt = {tx_level == 2'h1, link_tx_valid, retry_limit_flag,
		transmit_done_flag, receive_ready_flag};

	radio_mode_packet_controller #(.RX_SETTLE_CYCLES(20), .ACK_WAIT_CYCLES(2000))
	u_radio_mode_packet_controller (.sys_clk, .sys_rst, .link_clk, .chip_enable,
		.power_on_bit, .primary_receive_select, .acked_burst_method,
		.retry_limit, .tx_target_addr, .rx_base_addr, .tx_wr_valid, .tx_wr_data,
		.tx_wr_ready, .rx_rd_ready, .rx_rd_valid, .rx_rd_entry, .flag_clear,
		.flag_mask, .receive_ready_flag, .transmit_done_flag, .retry_limit_flag,
		.irq_n, .mode, .retry_count, .tx_level, .rx_level, .link_tx_bit,
		.link_tx_valid, .link_rx_bit, .link_rx_valid);
	link_peer u_link_peer (.link_clk, .link_tx_bit, .link_tx_valid,
		.link_rx_bit, .link_rx_valid, .ack_en);

	// Clocks; the link clock is offset so no edges line up
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Bounded wait: below 8 a mode, below 16 an event bit, else notes drained
	task automatic wait_for(input int k, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(negedge sys_clk);
			if (k < 8 ? mode === mode_e'(k) :
				k < 16 ? evt[k-8] === 1'b1 : exp_q.size() == 0) break;
		end
		check(i < lim, 1'b1);
	endtask
	// One framed access per call, released before the next
	task automatic push(input logic [DATA_W-1:0] b);
		@(negedge sys_clk);
		tx_wr_valid = 1'b1;
		tx_wr_data  = b;
		@(negedge sys_clk);
		tx_wr_valid = 1'b0;
	endtask
	task automatic pop_clear(input logic [N_FLAGS-1:0] c);
		@(negedge sys_clk);
		rx_rd_ready = c[FLAG_RX];
		flag_clear  = c;
		@(negedge sys_clk);
		rx_rd_ready = 1'b0;
		flag_clear  = 3'h0;
	endtask
	// Every frame the peer sees must match the oldest note
	initial forever begin
		@(u_link_peer.got);
		check(exp_q.size() > 0, 1'b1);
		if (exp_q.size() > 0) check(u_link_peer.got_frame, exp_q.pop_front());
	end
	// Hang guard, well beyond the expected run
	initial begin
		#450000;
		fails++;
		print_verdict();
	end

	initial begin
		seed = 32'ha6afb73b;
		{chip_enable, power_on_bit, primary_receive_select} = 3'h0;
		{acked_burst_method, tx_wr_valid, rx_rd_ready, ack_en} = 4'h0;
		// One retransmission allowed before the retry flag
		{flag_clear, flag_mask, retry_limit, tx_wr_data} = 18'h00100;
		tx_target_addr = 7'($random(seed));
		rx_base_addr   = 4'($random(seed));
		// Held long enough for the link side to see it too
		sys_rst = 1'b1;
		repeat (100) @(negedge sys_clk);
		sys_rst = 1'b0;
		check(mode, PWR_DOWN);
		check({irq_n, tx_wr_ready, rx_rd_valid}, 3'b110);
		// Fill the transmit queue while powered down; the fourth is refused
		for (int i = 0; i < 4; i++) begin
			pl[i] = 8'($random(seed));
			push(pl[i]);
		end
		check({tx_level, tx_wr_ready}, 3'b110);
		power_on_bit = 1'b1;
		wait_for(STBY_LOW, 20);
		check(tx_level, 2'h3);
		for (int i = 0; i < 3; i++)
			exp_q.push_back(u_link_peer.mk(1'b0, tx_target_addr, pl[i]));
		chip_enable = 1'b1;
		wait_for(TX_SEND, 10);
		wait_for(12, 6000);
		wait_for(11, 3000);
		chip_enable = 1'b0;
		wait_for(STBY_LOW, 3000);
		check({tx_level, transmit_done_flag, irq_n}, 4'b0010);
		flag_mask = 3'b010;
		@(negedge sys_clk);
		check(irq_n, 1'b1);
		flag_mask = 3'b000;
		pop_clear(3'b010);
		check({transmit_done_flag, irq_n}, 2'b01);
		chip_enable = 1'b1;
		wait_for(READY_IDLE, 10);
		// Receive on every pipe, then a bad pipe and a bad checksum
		primary_receive_select = 1'b1;
		wait_for(RX_ACTIVE, 40);
		for (int p = 0; p < 9; p++) begin
			d = 8'($random(seed));
			acked_burst_method = (p == 8);
			if (p == 8)
				exp_q.push_back(u_link_peer.mk(1'b1, {rx_base_addr, 3'h5}, 8'h00));
			u_link_peer.send(u_link_peer.mk(1'b0, {rx_base_addr,
				p > 6 ? 3'h5 : p[2:0]}, d) ^ (p == 7));
			repeat (20) @(negedge sys_clk);
			check(receive_ready_flag, p < PIPES || p == 8);
			if (p < PIPES || p == 8) begin
				check(rx_rd_entry, {(p == 8 ? 3'h5 : p[2:0]), d});
				pop_clear(3'b001);
			end
		end
		wait_for(20, 3000);
		// Done toggle needs a few cycles to reach the mode logic
		wait_for(RX_ACTIVE, 10);
		check({rx_level, mode}, {2'h0, RX_ACTIVE});
		// Acknowledged send: no reply until retries run out, then a reply
		primary_receive_select = 1'b0;
		for (int i = 0; i < 2; i++)
			exp_q.push_back(u_link_peer.mk(1'b0, tx_target_addr, pl[3]));
		push(pl[3]);
		wait_for(10, 12000);
		check(retry_count, 4'h1);
		check(tx_level, 2'h1);
		exp_q.push_back(u_link_peer.mk(1'b0, tx_target_addr, pl[3]));
		ack_en = 1'b1;
		pop_clear(3'b100);
		wait_for(9, 12000);
		check({tx_level, retry_limit_flag}, 3'b000);
		check(exp_q.size(), 0);
		print_verdict();
	end
endmodule
`default_nettype wire
